/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import tc16_pkg::*;
;
   logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic external_count_pin_i, osc_clk_i, osc_enable_i, overflow_irq_o;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, m;
   logic [3:0] wb_sel_i;
   logic [UNITS-1:0] special_event_i, timebase_sel_o;
   logic [1:0] port_pin_i, port_direction_bits_i, pin_oe_o, port_read_o;
   logic [15:0] count_o, c;
   logic [31:0] exp_q[$], msk_q[$];
   logic [4:0] tbx[4] = '{5'h00, 5'h1E, 5'h1C, 5'h1F};
   int mismatches = 0;
   int compares = 0;
   int k;

   tc16_top i_dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
      .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
      .external_count_pin_i, .osc_clk_i, .osc_enable_i, .special_event_i,
      .port_pin_i, .port_direction_bits_i, .pin_oe_o, .port_read_o,
      .timebase_sel_o, .overflow_irq_o, .count_o);

   always #10 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic hang();
      mismatches++;
      results();
   endtask

   task automatic bus(input logic [31:0] a, input logic w,
                      input logic [7:0] d);
      int n;
      n = 0;
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= {24'h0, d};
      wb_sel_i <= 4'h1;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      do begin
         @(posedge clk_i);
         n++;
         if (n > 50) hang();
      end while (wb_ack_o !== 1'h1);
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e,
                     input logic [31:0] mk);
      exp_q.push_back(e);
      msk_q.push_back(mk);
      bus(a, 1'h0, 8'h00);
   endtask

   task automatic wchg(output int n);
      logic [15:0] v;
      v = count_o;
      n = 0;
      while (count_o === v) begin
         @(posedge clk_i);
         n++;
         if (n > 200) hang();
      end
   endtask

   // Read results checked in arrival order
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && exp_q.size() > 0) begin
         m = msk_q.pop_front();
         check(wb_dat_o & m, exp_q.pop_front() & m);
      end
   end

   initial begin
      clk_i = 1'h0;
      rst_i = 1'h1;
      {wb_we_i, wb_cyc_i, wb_stb_i, osc_clk_i, osc_enable_i} = 5'h00;
      {wb_adr_i, wb_dat_i, wb_sel_i} = 68'h0;
      external_count_pin_i = 1'h0;
      special_event_i = 5'h00;
      {port_pin_i, port_direction_bits_i} = 4'h0;
      void'($urandom(61645));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      rd(32'h0, 32'h00, 32'hFFFFFFFF);
      bus(32'h10, 1'h1, 8'h5A);
      rd(32'h10, 32'h00, 32'hFFFFFFFF);
      rd(32'h0, 32'h00, 32'hFFFFFFFF);
      for (int i = 0; i < 4; i++) begin
         osc_enable_i <= i[0];
         port_direction_bits_i <= 2'($urandom);
         port_pin_i <= 2'($urandom);
         bus(32'h0, 1'h1, {1'h0, i[1], 2'h0, i[0], 3'h0});
         repeat (2) @(posedge clk_i);
         check(timebase_sel_o, tbx[i]);
         check({pin_oe_o, port_read_o},
            i[0] ? 4'h0 : {~port_direction_bits_i, port_pin_i});
      end
      osc_enable_i <= 1'h0;
      bus(32'h0, 1'h1, 8'h00);
      bus(32'h4, 1'h1, 8'h34);
      bus(32'h8, 1'h1, 8'h12);
      rd(32'h4, 32'h34, 32'hFF);
      rd(32'h8, 32'h12, 32'hFF);
      check(count_o, 16'h1234);
      bus(32'h0, 1'h1, 8'h80);
      bus(32'h8, 1'h1, 8'hAB);
      check(count_o, 16'h1234);
      bus(32'h4, 1'h1, 8'hCD);
      check(count_o, 16'hABCD);
      bus(32'h8, 1'h1, 8'h55);
      rd(32'h4, 32'hCD, 32'hFF);
      rd(32'h8, 32'hAB, 32'hFF);
      check(count_o, 16'hABCD);
      for (int p = 0; p < 4; p++) begin
         bus(32'h4, 1'h1, 8'h00);
         bus(32'h0, 1'h1, {2'h2, p[1:0], 4'h1});
         wchg(k);
         wchg(k);
         check(k, 4 << p);
      end
      // Prescaler phase is known just after a change
      repeat (16) @(posedge clk_i);
      bus(32'h4, 1'h1, 8'h00);
      wchg(k);
      check(k, 29);
      repeat (16) @(posedge clk_i);
      bus(32'h8, 1'h1, 8'h00);
      wchg(k);
      check(k, 13);
      bus(32'h0, 1'h1, 8'h80);
      repeat (3) @(posedge clk_i);
      c = count_o;
      repeat (40) @(posedge clk_i);
      check(count_o, c);
      bus(32'hC, 1'h1, 8'h02);
      bus(32'h8, 1'h1, 8'hFF);
      bus(32'h4, 1'h1, 8'hF0);
      bus(32'h0, 1'h1, 8'h81);
      k = 0;
      while (overflow_irq_o !== 1'h1) begin
         @(posedge clk_i);
         k++;
         if (k > 300) hang();
      end
      rd(32'hC, 32'h3, 32'h3);
      bus(32'hC, 1'h1, 8'h02);
      rd(32'hC, 32'h2, 32'h3);
      bus(32'h4, 1'h1, 8'h77);
      bus(32'h0, 1'h1, 8'hC9);
      repeat (8) @(posedge clk_i);
      special_event_i <= 5'(5'h01 << $urandom_range(4, 0));
      @(posedge clk_i);
      special_event_i <= 5'h00;
      @(posedge clk_i);
      check(count_o, 16'h0000);
      bus(32'h0, 1'h1, 8'hCF);
      bus(32'h4, 1'h1, 8'h77);
      c = count_o;
      special_event_i <= 5'h1F;
      @(posedge clk_i);
      special_event_i <= 5'h00;
      repeat (3) @(posedge clk_i);
      check(count_o, c);
      // First rise after reset comes before any fall
      for (int b = 0; b < 2; b++) begin
         bus(32'h0, 1'h1, {5'h00, b[0], 2'h3});
         bus(32'h4, 1'h1, 8'h00);
         bus(32'h8, 1'h1, 8'h00);
         repeat (5) begin
            external_count_pin_i <= 1'h1;
            repeat ($urandom_range(12, 6)) @(posedge clk_i);
            external_count_pin_i <= 1'h0;
            repeat ($urandom_range(12, 6)) @(posedge clk_i);
         end
         repeat (12) @(posedge clk_i);
         check(count_o, b ? 16'h5 : 16'h4);
      end
      results();
   end
endmodule

`default_nettype wire

/* File: bench/tc16_props.sv */
`timescale 1ns/1ps
`default_nettype none

module tc16_props
   import tc16_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic osc_enable_i,
   input wire logic [UNITS-1:0] special_event_i,
   input wire logic [1:0] pin_oe_o,
   input wire logic [1:0] port_read_o,
   input wire logic [UNITS-1:0] timebase_sel_o,
   input wire logic overflow_irq_o,
   input wire logic [15:0] count_o
);
   logic take, wr, wr_low, wr_cnt, live_q, ie_q, hi, lo;
   logic [7:0] ctrl_q;
   logic [UNITS-1:0] tb_map;

   assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = take & wb_we_i & wb_sel_i[0] & ~|wb_adr_i[31:4];
   assign wr_low = wr & (wb_adr_i[3:0] == ADR_LOW);
   assign wr_cnt = wr_low | (wr & (wb_adr_i[3:0] == ADR_HIGH));
   assign hi = ctrl_q[CTL_TB_HI];
   assign lo = ctrl_q[CTL_TB_LO];
   assign tb_map = {{3{hi | lo}}, lo, hi & lo};

   // Shadow of control and enable as written over the bus
   always_ff @(posedge clk_i) begin
      live_q <= ~rst_i;
      if (rst_i) begin
         ctrl_q <= 8'h00;
         ie_q <= 1'h0;
      end else if (wr && wb_adr_i[3:0] == ADR_CTRL) begin
         ctrl_q <= wb_dat_i[7:0];
      end else if (wr && wb_adr_i[3:0] == ADR_STAT) begin
         ie_q <= wb_dat_i[STAT_IE];
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_ack;
      take |=> wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_step;
      live_q && !$past(wr_cnt) && $past(special_event_i) == 5'h00
         |-> count_o == $past(count_o) || count_o == $past(count_o) + 16'h1;
   endproperty
   a_step: assert property (p_step) else $error("bad step");
   property p_hold;
      live_q && !ctrl_q[CTL_RUN] && !$past(ctrl_q[CTL_RUN])
         && !$past(ctrl_q[CTL_RUN], 2) && !$past(wr_cnt)
         && $past(special_event_i) == 5'h00 |-> $stable(count_o);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved");
   property p_tb;
      live_q && $stable(ctrl_q) |-> timebase_sel_o == tb_map;
   endproperty
   a_tb: assert property (p_tb) else $error("bad map");
   property p_osc;
      $past(osc_enable_i) |-> pin_oe_o == 2'h0 && port_read_o == 2'h0;
   endproperty
   a_osc: assert property (p_osc) else $error("pins not input");
   property p_gate;
      overflow_irq_o |-> $past(ie_q);
   endproperty
   a_gate: assert property (p_gate) else $error("irq not enabled");
   property p_wrap;
      live_q && ie_q && count_o == 16'h0000 && $past(count_o) == 16'hFFFF
         && !$past(wr_cnt) && $past(special_event_i) == 5'h00
         |=> overflow_irq_o;
   endproperty
   a_wrap: assert property (p_wrap) else $error("no irq on wrap");
   property p_trig;
      live_q && $past(|(special_event_i & timebase_sel_o))
         && !$past(wr_cnt) && !$past(ctrl_q[CTL_CS] && ctrl_q[CTL_BYP])
         |-> count_o == 16'h0000;
   endproperty
   a_trig: assert property (p_trig) else $error("no clear");
   property p_wins;
      live_q && $past(wr_low) |-> count_o[7:0] == $past(wb_dat_i[7:0]);
   endproperty
   a_wins: assert property (p_wins) else $error("write lost");

   c_irq: cover property (overflow_irq_o);
   c_trig: cover property (|(special_event_i & timebase_sel_o));
   c_wide: cover property (ctrl_q[CTL_WIDE] && wr_low);
endmodule

bind tc16_top tc16_props i_props (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
   .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .osc_enable_i,
   .special_event_i, .pin_oe_o, .port_read_o, .timebase_sel_o,
   .overflow_irq_o, .count_o);

`default_nettype wire

/* File: logic/tc16_cnt_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface tc16_cnt_if;
   logic evt;
   logic clr;
   logic [1:0] sel;
   logic tick;

   modport src_mp (output evt);
   modport pre_mp (input evt, input clr, input sel, output tick);
   modport core_mp (input tick, output clr, output sel);
endinterface

`default_nettype wire

/* File: logic/tc16_edge.sv */
`timescale 1ns/1ps
`default_nettype none

module tc16_edge
   import tc16_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic instr_en_i,
   input wire logic run_i,
   input wire logic src_ext_i,
   input wire logic bypass_i,
   input wire logic pin_i,
   output logic armed_o,
   tc16_cnt_if.src_mp cnt
);
   logic s1_q, s2_q, s3_q, raw_q, pend_q, armed_q;
   logic cur, prv, rise, fall, ext_evt;

   // Two-stage synchroniser plus history
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         raw_q <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         raw_q <= pin_i;
      end
   end

   always_comb begin
      cur = bypass_i ? pin_i : s2_q;
      prv = bypass_i ? raw_q : s3_q;
      rise = cur & ~prv;
      fall = ~cur & prv;
   end

   // Count only rising edges after a falling edge
   always_ff @(posedge clk_i) begin
      if (rst_i || !src_ext_i || !run_i) begin
         armed_q <= 1'b0;
      end else if (fall) begin
         armed_q <= 1'b1;
      end
   end

   // Synchronous mode releases an edge on the instruction cycle
   always_ff @(posedge clk_i) begin
      if (rst_i || bypass_i || !src_ext_i || !run_i) begin
         pend_q <= 1'b0;
      end else if (instr_en_i) begin
         pend_q <= 1'b0;
      end else if (rise && armed_q) begin
         pend_q <= 1'b1;
      end
   end

   always_comb begin
      if (bypass_i) begin
         ext_evt = rise & armed_q;
      end else begin
         ext_evt = instr_en_i & (pend_q | (rise & armed_q));
      end
      cnt.evt = run_i & (src_ext_i ? ext_evt : instr_en_i);
   end

   assign armed_o = armed_q;

endmodule

`default_nettype wire

/* File: logic/tc16_pkg.sv */
package tc16_pkg;

   // Bus byte addresses, decoded on the low nibble
   localparam int unsigned ADR_W = 4;
   localparam logic [ADR_W-1:0] ADR_CTRL = 4'h0;
   localparam logic [ADR_W-1:0] ADR_LOW = 4'h4;
   localparam logic [ADR_W-1:0] ADR_HIGH = 4'h8;
   localparam logic [ADR_W-1:0] ADR_STAT = 4'hC;

   // Control register fields
   localparam int unsigned CTL_RUN = 0;
   localparam int unsigned CTL_CS = 1;
   localparam int unsigned CTL_BYP = 2;
   localparam int unsigned CTL_TB_LO = 3;
   localparam int unsigned CTL_PS_LO = 4;
   localparam int unsigned CTL_PS_HI = 5;
   localparam int unsigned CTL_TB_HI = 6;
   localparam int unsigned CTL_WIDE = 7;

   // Status register fields
   localparam int unsigned STAT_FLAG = 0;
   localparam int unsigned STAT_IE = 1;
   localparam int unsigned STAT_ARMED = 2;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [31:0] DAT_ZERO = 32'h0000_0000;

   // Instruction cycle is the system clock divided by four
   localparam int unsigned INSTR_DIV = 4;
   localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
   localparam logic [1:0] DIV_RST = 2'h0;

   // Oscillator pins shared with the port
   localparam int unsigned PINS = 2;

   // Capture/compare/PWM unit assignment
   localparam int unsigned UNITS = 5;
   localparam logic [1:0] TB_NONE = 2'h0;
   localparam logic [1:0] TB_UPPER4 = 2'h1;
   localparam logic [1:0] TB_UPPER3 = 2'h2;
   localparam logic [1:0] TB_ALL = 2'h3;
   localparam logic [UNITS-1:0] TBM_NONE = 5'h00;
   localparam logic [UNITS-1:0] TBM_UPPER4 = 5'h1E;
   localparam logic [UNITS-1:0] TBM_UPPER3 = 5'h1C;
   localparam logic [UNITS-1:0] TBM_ALL = 5'h1F;

   // Prescale codes and the last count of each
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV2 = 2'h1;
   localparam logic [1:0] PS_DIV4 = 2'h2;
   localparam logic [2:0] PS_ZERO = 3'h0;

   typedef enum logic [1:0] {
      TC16_TIMER,
      TC16_SYNC_CNT,
      TC16_ASYNC_CNT
   } tc16_mode_t;

   function automatic logic [2:0] tc16_ps_last(input logic [1:0] sel);
      case (sel)
         PS_DIV1: tc16_ps_last = 3'h0;
         PS_DIV2: tc16_ps_last = 3'h1;
         PS_DIV4: tc16_ps_last = 3'h3;
         default: tc16_ps_last = 3'h7;
      endcase
   endfunction

endpackage

/* File: logic/tc16_presc.sv */
`timescale 1ns/1ps
`default_nettype none

module tc16_presc
   import tc16_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   tc16_cnt_if.pre_mp cnt
);
   logic [2:0] ps_q;
   logic tick_q;

   always_ff @(posedge clk_i) begin
      if (rst_i || cnt.clr) begin
         ps_q <= PS_ZERO;
         tick_q <= 1'b0;
      end else if (cnt.evt) begin
         if (ps_q >= tc16_ps_last(cnt.sel)) begin
            ps_q <= PS_ZERO;
            tick_q <= 1'b1;
         end else begin
            ps_q <= 3'(ps_q + 3'h1);
            tick_q <= 1'b0;
         end
      end else begin
         tick_q <= 1'b0;
      end
   end

   assign cnt.tick = tick_q;

endmodule

`default_nettype wire

/* File: logic/tc16_top.sv */
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module tc16_top
   import tc16_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic external_count_pin_i,
   input wire logic osc_clk_i,
   input wire logic osc_enable_i,
   input wire logic [UNITS-1:0] special_event_i,
   input wire logic [1:0] port_pin_i,
   input wire logic [1:0] port_direction_bits_i,
   output logic [1:0] pin_oe_o,
   output logic [1:0] port_read_o,
   output logic [UNITS-1:0] timebase_sel_o,
   output logic overflow_irq_o,
   output logic [15:0] count_o
);

   ////////////////////////////////////////////////////////////////////////
   // Registers and decode

   logic [7:0] ctrl_q;
   logic [15:0] count_q;
   logic [7:0] hbuf_q;
   logic flag_q;
   logic ie_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic irq_q;
   logic [UNITS-1:0] tb_q;
   logic [1:0] oe_q;
   logic [1:0] prd_q;
   logic [1:0] div_q;
   logic instr_en_q;
   logic armed;

   logic req, wr, rd, in_map;
   logic hit_ctrl, hit_low, hit_high, hit_stat;
   logic [7:0] wdat;
   logic wide, run, cs, byp;
   logic [1:0] tb_code;
   logic [UNITS-1:0] tb_d;
   tc16_mode_t mode;
   logic trig, tick_go, wr_count, ovf_set;
   logic [31:0] dat_d;

   tc16_cnt_if cnt ();

   always_comb begin
      req = wb_cyc_i & wb_stb_i & ~ack_q;
      in_map = (wb_adr_i[31:ADR_W] == '0);
      hit_ctrl = in_map && (wb_adr_i[ADR_W-1:0] == ADR_CTRL);
      hit_low = in_map && (wb_adr_i[ADR_W-1:0] == ADR_LOW);
      hit_high = in_map && (wb_adr_i[ADR_W-1:0] == ADR_HIGH);
      hit_stat = in_map && (wb_adr_i[ADR_W-1:0] == ADR_STAT);
      wr = req & wb_we_i & wb_sel_i[0];
      rd = req & ~wb_we_i;
      wdat = wb_dat_i[7:0];
      wide = ctrl_q[CTL_WIDE];
      run = ctrl_q[CTL_RUN];
      cs = ctrl_q[CTL_CS];
      byp = ctrl_q[CTL_BYP];
      tb_code = {ctrl_q[CTL_TB_HI], ctrl_q[CTL_TB_LO]};
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode decode

   always_comb begin
      if (!cs) begin
         mode = TC16_TIMER;
      end else if (byp) begin
         mode = TC16_ASYNC_CNT;
      end else begin
         mode = TC16_SYNC_CNT;
      end
   end

   // Units served by this timer pair
   always_comb begin
      case (tb_code)
         TB_ALL: tb_d = TBM_ALL;
         TB_UPPER3: tb_d = TBM_UPPER3;
         TB_UPPER4: tb_d = TBM_UPPER4;
         TB_NONE: tb_d = TBM_NONE;
         default: tb_d = TBM_NONE;
      endcase
   end

   // Trigger honoured only in timer and synchronous counter modes
   always_comb begin
      case (mode)
         TC16_TIMER: trig = |(special_event_i & tb_q);
         TC16_SYNC_CNT: trig = |(special_event_i & tb_q);
         TC16_ASYNC_CNT: trig = 1'b0;
         default: trig = 1'b0;
      endcase
      wr_count = wr & (hit_low | (hit_high & ~wide));
      tick_go = cnt.tick & run;
      ovf_set = tick_go & (count_q == COUNT_MAX) & ~wr_count & ~trig;
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction-cycle divider

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= DIV_RST;
         instr_en_q <= 1'b0;
      end else begin
         div_q <= 2'(div_q + 2'h1);
         instr_en_q <= (div_q == INSTR_LAST);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Count source and prescaler

   assign cnt.clr = wr & hit_low;
   assign cnt.sel = ctrl_q[CTL_PS_HI:CTL_PS_LO];

   tc16_edge u_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .instr_en_i(instr_en_q),
      .run_i(run),
      .src_ext_i(cs),
      .bypass_i(byp),
      .pin_i(osc_enable_i ? osc_clk_i : external_count_pin_i),
      .armed_o(armed),
      .cnt(cnt.src_mp)
   );

   tc16_presc u_presc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cnt(cnt.pre_mp)
   );

   ////////////////////////////////////////////////////////////////////////
   // Control register

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RST;
      end else if (wr && hit_ctrl) begin
         ctrl_q <= wdat;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Count register

   // Writes outrank the trigger, the trigger outranks counting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_q <= COUNT_RST;
      end else if (wr && hit_low) begin
         count_q <= {wide ? hbuf_q : count_q[15:8], wdat};
      end else if (wr && hit_high && !wide) begin
         count_q[15:8] <= wdat;
      end else if (trig) begin
         count_q <= COUNT_RST;
      end else if (tick_go) begin
         count_q <= 16'(count_q + 16'h0001);
      end
   end

   // High-byte buffer for wide access
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hbuf_q <= BYTE_RST;
      end else if (wide && rd && hit_low) begin
         hbuf_q <= count_q[15:8];
      end else if (wide && wr && hit_high) begin
         hbuf_q <= wdat;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Overflow flag and request

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= 1'b0;
      end else if (ovf_set) begin
         flag_q <= 1'b1;
      end else if (wr && hit_stat && !wdat[STAT_FLAG]) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ie_q <= 1'b0;
      end else if (wr && hit_stat) begin
         ie_q <= wdat[STAT_IE];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (flag_q | ovf_set) & ie_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins, unit assignment, count view

   // One slice per oscillator pin; enabled oscillator owns both pins
   for (genvar p = 0; p < PINS; p++) begin : g_pin
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            oe_q[p] <= 1'b0;
            prd_q[p] <= 1'b0;
         end else begin
            oe_q[p] <= ~osc_enable_i & ~port_direction_bits_i[p];
            prd_q[p] <= ~osc_enable_i & port_pin_i[p];
         end
      end
   end

   // Routing follows a control write by one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tb_q <= TBM_NONE;
      end else begin
         tb_q <= tb_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wishbone answer

   // Ack one cycle after the request; read data latched at that edge
   always_comb begin
      dat_d = DAT_ZERO;
      if (hit_ctrl) begin
         dat_d[7:0] = ctrl_q;
      end else if (hit_low) begin
         dat_d[7:0] = count_q[7:0];
      end else if (hit_high) begin
         dat_d[7:0] = wide ? hbuf_q : count_q[15:8];
      end else if (hit_stat) begin
         dat_d[STAT_FLAG] = flag_q;
         dat_d[STAT_IE] = ie_q;
         dat_d[STAT_ARMED] = armed;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= DAT_ZERO;
      end else begin
         ack_q <= req;
         if (rd) begin
            dat_q <= dat_d;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign overflow_irq_o = irq_q;
   assign timebase_sel_o = tb_q;
   assign pin_oe_o = oe_q;
   assign port_read_o = prd_q;
   assign count_o = count_q;

endmodule

`default_nettype wire
